// ---- logic/comc_pkg.sv ----
package comc_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int DELAY_UNIT_NS = 1000;
  localparam int DELAY_UNIT_CYCLES = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_INTERVAL = 15;
  localparam int INT_DIGITS = 5;
  localparam int FRAC_DIGITS = 2;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] DEFAULT_ADDR = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] CHAR_STAR = 8'h2a;
  localparam logic [7:0] CHAR_PLUS = 8'h2b;
  localparam logic [7:0] CHAR_MINUS = 8'h2d;
  localparam logic [7:0] CHAR_DOT = 8'h2e;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_LF = 8'h0a;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [3:0] POS_STAR = 4'h0;
  localparam logic [3:0] POS_SIGN = 4'h1;
  localparam logic [3:0] POS_INT0 = 4'h2;
  localparam logic [3:0] POS_DOT = 4'h7;
  localparam logic [3:0] POS_FRAC0 = 4'h8;
  localparam logic [3:0] POS_CR = 4'ha;
  localparam logic [3:0] POS_LF = 4'hb;
  typedef enum {COMC_IDLE, COMC_DELAY, COMC_SEND} comc_state_type;
endpackage

// ---- logic/comc_stream_if.sv ----
`timescale 1ns/1ps
interface comc_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- logic/comc_fmt.sv ----
`timescale 1ns/1ps
module comc_fmt
  import comc_pkg::*;
#(
  parameter int NDIG = INT_DIGITS + FRAC_DIGITS
)(
  input wire logic [3:0] pos,
  input wire logic negative,
  input wire logic [4*NDIG-1:0] digits,
  output logic [7:0] char_out
);
  import comc_pkg::*;

  initial begin
    if (NDIG != INT_DIGITS + FRAC_DIGITS) begin
      $error("comc_fmt: digit count must match the fixed field layout");
    end
  end

  // Digit 0 is the most significant integer digit
  wire [3:0] int_sel = 4'(pos - POS_INT0);
  wire [3:0] frac_sel = 4'(pos - POS_FRAC0 + 4'(INT_DIGITS));
  wire [3:0] dig_sel = (pos >= POS_FRAC0) ? frac_sel : int_sel;
  wire [3:0] dig_val = digits[4*(NDIG-1-int'(dig_sel)) +: 4];
  wire [7:0] dig_char = CHAR_ZERO | {4'h0, dig_val};
  wire [7:0] sign_char = negative ? CHAR_MINUS : CHAR_PLUS;

  assign char_out = (pos == POS_STAR) ? CHAR_STAR :
                    (pos == POS_SIGN) ? sign_char :
                    (pos == POS_DOT) ? CHAR_DOT :
                    (pos == POS_CR) ? CHAR_CR :
                    (pos == POS_LF) ? CHAR_LF : dig_char;
endmodule

// ---- logic/comc_buf.sv ----
`timescale 1ns/1ps
module comc_buf
  import comc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)(
  input wire logic core_clk,
  input wire logic reset_n,
  comc_stream_if.snk fill,
  comc_stream_if.src drain
);
  import comc_pkg::*;

  initial begin
    if (DEPTH != 2 || WIDTH < 1) begin
      $error("comc_buf: only a two-entry buffer is supported");
    end
  end

  // Output stage plus one skid entry, so ready never depends on drain combinationally
  logic out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic skid_valid_reg;
  logic [WIDTH-1:0] skid_data_reg;

  wire fill_fire = fill.valid && !skid_valid_reg;
  wire out_free = drain.ready || !out_valid_reg;

  assign fill.ready = !skid_valid_reg;
  assign drain.valid = out_valid_reg;
  assign drain.data = out_data_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
      skid_valid_reg <= 1'b0;
      skid_data_reg <= '0;
    end else if (out_free) begin
      out_valid_reg <= skid_valid_reg || fill_fire;
      out_data_reg <= skid_valid_reg ? skid_data_reg : fill.data;
      skid_valid_reg <= 1'b0;
    end else if (fill_fire) begin
      skid_valid_reg <= 1'b1;
      skid_data_reg <= fill.data;
    end
  end

  full_holds_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    skid_valid_reg && !drain.ready |=> skid_valid_reg && out_valid_reg && $stable(out_data_reg))
    else $error("buffer entry lost while drain stalled");
endmodule

// ---- logic/comc_top.sv ----
`timescale 1ns/1ps
// Contract
// R1: A low stream select makes the block send readings unprompted, over and over.
// R2: A high or floating stream select keeps normal addressed command and reply traffic.
// R3: Each streamed reading is an asterisk, the value, then a carriage return.
// R4: The configured message delay and trailing line feed are added when setup enables them.
// R5: With stream select low every received command is dropped and never answered.
// R6: One message leaves after each finished conversion, about eight per second.
// R7: A message in flight is always finished before the next starts, so slow links set the pace.
// R8: Every fifteenth conversion triggers an auto-calibration, leaving a gap in the stream.
// R9: Only one streaming unit may sit on a given line.
// R10: An unused receive input must be grounded so no line break is seen.
// R11: A grounded default-mode input forces the answer address to 1.
// R12: For streaming the system leaves default-mode open and holds stream select low.
// R13: Values are sent as sign, five integer digits, a point and two fraction digits.
// R14: Each message carries the newest finished conversion, and each result goes out once; a result replaced before its message starts is never sent.
module comc_top
  import comc_pkg::*;
#(
  parameter int DELAY_W = 16
)(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic stream_select_n,
  input wire logic default_mode_n,
  input wire logic conv_done,
  input wire logic conv_negative,
  input wire logic [4*(INT_DIGITS+FRAC_DIGITS)-1:0] conv_digits,
  output logic cal_request,
  input wire logic [ADDR_W-1:0] cfg_addr,
  input wire logic cfg_linefeed_en,
  input wire logic cfg_delay_en,
  input wire logic [DELAY_W-1:0] cfg_delay_units,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic [ADDR_W-1:0] answer_addr,
  input wire logic resp_valid,
  input wire logic [7:0] resp_byte,
  output logic resp_ready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  output logic stream_active
);
  import comc_pkg::*;

  localparam int NDIG = INT_DIGITS + FRAC_DIGITS;
  localparam logic [7:0] UNIT_LAST = 8'(DELAY_UNIT_CYCLES - 1);
  localparam logic [3:0] CAL_LAST = 4'(CAL_INTERVAL - 1);

  initial begin
    if (DELAY_W < 1 || DELAY_UNIT_CYCLES > 256 || CAL_INTERVAL > 16) begin
      $error("comc_top: parameter outside the supported range");
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  logic sel_meta_reg;
  logic sel_sync_reg;
  logic def_meta_reg;
  logic def_sync_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_meta_reg <= 1'b1;
      sel_sync_reg <= 1'b1;
      def_meta_reg <= 1'b1;
      def_sync_reg <= 1'b1;
    end else begin
      sel_meta_reg <= stream_select_n;
      sel_sync_reg <= sel_meta_reg;
      def_meta_reg <= default_mode_n;
      def_sync_reg <= def_meta_reg;
    end
  end

  comc_state_type state_reg;
  comc_state_type state_next;
  logic stream_reg;
  logic pending_reg;
  logic msg_neg_reg;
  logic [4*NDIG-1:0] msg_digits_reg;
  logic pend_neg_reg;
  logic [4*NDIG-1:0] pend_digits_reg;
  logic [3:0] pos_reg;
  logic [7:0] unit_cnt_reg;
  logic [DELAY_W-1:0] delay_left_reg;
  logic [3:0] conv_cnt_reg;
  logic cal_req_reg;
  logic cmd_valid_reg;
  logic [7:0] cmd_byte_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] fmt_char;

  comc_stream_if #(.WIDTH(8)) fill_if ();
  comc_stream_if #(.WIDTH(8)) drain_if ();

  comc_fmt #(.NDIG(NDIG)) fmt_u (
    .pos(pos_reg),
    .negative(msg_neg_reg),
    .digits(msg_digits_reg),
    .char_out(fmt_char)
  );

  comc_buf #(.WIDTH(8), .DEPTH(2)) buf_u (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .fill(fill_if.snk),
    .drain(drain_if.src)
  );

  // Decode
  wire idle = (state_reg == COMC_IDLE);
  wire [3:0] last_pos = cfg_linefeed_en ? POS_LF : POS_CR; // R4
  wire sending = (state_reg == COMC_SEND);
  wire push = sending && fill_if.ready;
  wire last_push = push && (pos_reg == last_pos);
  wire start_msg = idle && stream_reg && pending_reg; // R1 R6
  wire delay_zero = !cfg_delay_en || (cfg_delay_units == '0);
  wire unit_wrap = (unit_cnt_reg == UNIT_LAST);
  wire delay_done = unit_wrap && (delay_left_reg == DELAY_W'(1));
  wire cal_due = conv_done && (conv_cnt_reg == CAL_LAST);

  // Stream owns the transmitter for the whole of stream mode, which changes only at message boundaries
  assign fill_if.valid = stream_reg ? sending : resp_valid; // R2
  assign fill_if.data = stream_reg ? fmt_char : resp_byte;
  assign resp_ready = !stream_reg && fill_if.ready;
  assign drain_if.ready = tx_ready;
  assign tx_valid = drain_if.valid;
  assign tx_byte = drain_if.data;
  assign stream_active = stream_reg;
  assign cal_request = cal_req_reg;
  assign cmd_valid = cmd_valid_reg;
  assign cmd_byte = cmd_byte_reg;
  assign answer_addr = addr_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      COMC_IDLE: begin
        if (start_msg) begin
          state_next = delay_zero ? COMC_SEND : COMC_DELAY; // R4
        end
      end
      COMC_DELAY: begin
        if (delay_done) begin
          state_next = COMC_SEND;
        end
      end
      COMC_SEND: begin
        if (last_push) begin
          state_next = COMC_IDLE; // R7
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= COMC_IDLE;
      stream_reg <= 1'b0;
      pos_reg <= POS_STAR;
    end else begin
      state_reg <= state_next;
      // Mode changes wait for a message boundary; a frame starting in the cycle stream mode ends is never sent
      if (idle) begin
        stream_reg <= !sel_sync_reg; // R1 R2
      end
      if (start_msg) begin
        pos_reg <= POS_STAR; // R3
      end else if (push) begin
        pos_reg <= 4'(pos_reg + 4'h1);
      end
    end
  end

  // Newest result replaces an unsent one; a fresh result beats the clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_reg <= 1'b0;
      pend_neg_reg <= 1'b0;
      pend_digits_reg <= '0;
      msg_neg_reg <= 1'b0;
      msg_digits_reg <= '0;
    end else begin
      if (conv_done) begin
        pending_reg <= 1'b1; // R14
        pend_neg_reg <= conv_negative;
        pend_digits_reg <= conv_digits;
      end else if (start_msg || !stream_reg) begin
        pending_reg <= 1'b0; // R14
      end
      if (start_msg) begin
        msg_neg_reg <= pend_neg_reg; // R13
        msg_digits_reg <= pend_digits_reg;
      end
    end
  end

  // Message delay in whole microsecond units
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      unit_cnt_reg <= 8'h00;
      delay_left_reg <= '0;
    end else if (start_msg) begin
      unit_cnt_reg <= 8'h00;
      delay_left_reg <= cfg_delay_units; // R4
    end else if (state_reg == COMC_DELAY) begin
      unit_cnt_reg <= unit_wrap ? 8'h00 : 8'(unit_cnt_reg + 8'h01);
      if (unit_wrap) begin
        delay_left_reg <= DELAY_W'(delay_left_reg - DELAY_W'(1));
      end
    end
  end

  // Conversion count for auto-calibration; counts in both modes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_cnt_reg <= 4'h0;
      cal_req_reg <= 1'b0;
    end else begin
      cal_req_reg <= cal_due; // R8
      if (conv_done) begin
        conv_cnt_reg <= cal_due ? 4'h0 : 4'(conv_cnt_reg + 4'h1); // R8
      end
    end
  end

  // Command forwarding and answer address
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_valid_reg <= 1'b0;
      cmd_byte_reg <= 8'h00;
      addr_reg <= ADDR_RESET;
    end else begin
      cmd_valid_reg <= rx_valid && !stream_reg; // R5 R2
      if (rx_valid) begin
        cmd_byte_reg <= rx_byte;
      end
      addr_reg <= def_sync_reg ? cfg_addr : DEFAULT_ADDR; // R11 R12
    end
  end

  sequence msg_begin_s;
    start_msg;
  endsequence

  sequence frame_tail_s;
    last_push && !cfg_linefeed_en;
  endsequence

  cmd_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R5
    stream_reg && rx_valid |=> !cmd_valid)
    else $error("command passed while streaming");

  cmd_pass_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
    !stream_reg && rx_valid |=> cmd_valid && cmd_byte == $past(rx_byte))
    else $error("command lost in normal mode");

  default_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
    !def_sync_reg |=> answer_addr == DEFAULT_ADDR)
    else $error("default address not forced");

  frame_head_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
    msg_begin_s ##1 (state_reg == COMC_SEND) |-> pos_reg == POS_STAR && fmt_char == CHAR_STAR)
    else $error("message does not open with asterisk");

  frame_tail_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
    frame_tail_s |-> fmt_char == CHAR_CR ##1 idle)
    else $error("message does not end with carriage return");

  linefeed_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R4
    push && pos_reg == POS_CR && cfg_linefeed_en |=> sending && pos_reg == POS_LF)
    else $error("line feed missing");

  stream_start_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R6
    msg_begin_s and (delay_zero) |=> sending)
    else $error("message not started after conversion");

  no_overlap_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R7
    sending && !last_push |=> sending)
    else $error("message interrupted");

  single_send_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R14
    msg_begin_s and (!conv_done) |=> !pending_reg)
    else $error("reading queued twice");

  cal_pulse_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
    conv_done && conv_cnt_reg == CAL_LAST |=> cal_request && conv_cnt_reg == 4'h0 ##1 !cal_request)
    else $error("calibration not requested on fifteenth conversion");

  digit_fmt_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R13
    push && pos_reg == POS_DOT |-> fmt_char == CHAR_DOT)
    else $error("decimal point misplaced");
endmodule

// ---- bench/comc_host_model.sv ----
`timescale 1ns/1ps
module comc_host_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic stall,
  output logic tx_ready
);
  // Sole listener on the line, so no other unit ever streams here
  logic [3:0] phase_reg;
  initial begin
    tx_ready = 1'b1;
    phase_reg = 4'h0;
  end
  // Slow mode takes one byte in four, like a slow baud rate
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= 4'h0;
    end else begin
      phase_reg <= #1 phase_reg + 4'h1;
      tx_ready <= #1 !stall || (phase_reg[1:0] == 2'h3);
    end
  end
endmodule

// ---- bench/comc_top_tb.sv ----
`timescale 1ns/1ps
module comc_top_tb;
  import comc_pkg::*;
  localparam int NDIG = INT_DIGITS + FRAC_DIGITS;
  logic core_clk, reset_n, stream_select_n, default_mode_n, conv_done, conv_negative, cal_request;
  logic [4*NDIG-1:0] conv_digits;
  logic [ADDR_W-1:0] cfg_addr, answer_addr;
  logic cfg_linefeed_en, cfg_delay_en, rx_valid, cmd_valid, resp_valid, resp_ready, tx_valid, tx_ready;
  logic stream_active, stall;
  logic [15:0] cfg_delay_units, lfsr_reg;
  logic [7:0] rx_byte, cmd_byte, resp_byte, tx_byte;
  logic [7:0] tx_q[$];
  logic [7:0] cmd_q[$];
  int miscompares, samples_checked, conv_count, cal_count, n;

  comc_top dut (.core_clk(core_clk), .reset_n(reset_n), .stream_select_n(stream_select_n),
    .default_mode_n(default_mode_n), .conv_done(conv_done), .conv_negative(conv_negative),
    .conv_digits(conv_digits), .cal_request(cal_request), .cfg_addr(cfg_addr),
    .cfg_linefeed_en(cfg_linefeed_en), .cfg_delay_en(cfg_delay_en), .cfg_delay_units(cfg_delay_units),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .answer_addr(answer_addr), .resp_valid(resp_valid), .resp_byte(resp_byte), .resp_ready(resp_ready),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .stream_active(stream_active));
  comc_host_model host (.core_clk(core_clk), .reset_n(reset_n), .stall(stall), .tx_ready(tx_ready));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Every expected byte leaves the tx port exactly once, in order
  always @(posedge core_clk) begin
    if (reset_n && tx_valid && tx_ready) begin
      if (tx_q.size() == 0) check("tx_unexpected", 32'h0, 32'h1);
      else check("tx_byte", tx_q.pop_front(), tx_byte);
    end
    if (reset_n && cmd_valid) begin
      if (cmd_q.size() == 0) check("cmd_unexpected", 32'h0, 32'h1);
      else check("cmd_byte", cmd_q.pop_front(), cmd_byte);
    end
    if (reset_n && cal_request) cal_count++;
  end

  task automatic conv(logic expect_msg);
    logic [4*NDIG-1:0] d;
    logic neg;
    for (int i = 0; i < NDIG; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      d[4*i +: 4] = 4'(lfsr_reg % 16'd10);
    end
    neg = lfsr_reg[7];
    if (expect_msg) begin
      tx_q.push_back(CHAR_STAR);
      tx_q.push_back(neg ? CHAR_MINUS : CHAR_PLUS);
      for (int i = NDIG - 1; i >= 0; i--) begin
        tx_q.push_back(CHAR_ZERO + {4'h0, d[4*i +: 4]});
        if (i == FRAC_DIGITS) tx_q.push_back(CHAR_DOT);
      end
      tx_q.push_back(CHAR_CR);
      if (cfg_linefeed_en) tx_q.push_back(CHAR_LF);
    end
    @(posedge core_clk);
    #1;
    conv_done = 1'b1;
    conv_negative = neg;
    conv_digits = d;
    @(posedge core_clk);
    #1;
    conv_done = 1'b0;
    conv_count++;
  endtask

  task automatic send_rx(int count, logic answered);
    for (int i = 0; i < count; i++) begin
      @(posedge core_clk);
      #1;
      lfsr_reg = lfsr_next(lfsr_reg);
      rx_valid = 1'b1;
      rx_byte = lfsr_reg[7:0];
      if (answered) cmd_q.push_back(rx_byte);
    end
    @(posedge core_clk);
    #1;
    rx_valid = 1'b0;
  endtask

  task automatic send_resp(int count);
    int k;
    for (int i = 0; i < count; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      resp_valid = 1'b1;
      resp_byte = lfsr_reg[7:0];
      k = 0;
      do begin
        @(posedge core_clk);
        k++;
      end while (resp_ready !== 1'b1 && k < 1000);
      if (k >= 1000) check("resp_timeout", 32'h0, 32'h1);
      tx_q.push_back(resp_byte);
      #1;
    end
    resp_valid = 1'b0;
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (tx_q.size() != 0 && k < 5000) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 5000) check("drain_timeout", 32'h0, 32'h1);
    repeat (20) @(posedge core_clk);
    #1;
  endtask

  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    {reset_n, conv_done, conv_negative, conv_digits, resp_valid, resp_byte} = '0;
    {cfg_linefeed_en, cfg_delay_en, stall, conv_count, cal_count} = '0;
    {rx_valid, rx_byte} = '0;
    stream_select_n = 1'b1;
    default_mode_n = 1'b1;
    cfg_addr = 8'h5a;
    cfg_delay_units = 16'h0002;
    lfsr_reg = 16'hc8b7;
    repeat (6) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check("answer_addr", cfg_addr, answer_addr);
    check("stream_active", 32'h0, stream_active);
    send_rx(4, 1'b1);
    conv(1'b0);
    stall = 1'b1;
    send_resp(3);
    drain();
    stall = 1'b0;
    default_mode_n = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    check("answer_addr", DEFAULT_ADDR, answer_addr);
    default_mode_n = 1'b1;
    stream_select_n = 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    check("stream_active", 32'h1, stream_active);
    check("resp_ready", 32'h0, resp_ready);
    send_rx(3, 1'b0);
    for (int m = 0; m < 4; m++) begin
      cfg_linefeed_en = m[0];
      stall = m[1];
      conv(1'b1);
      drain();
    end
    stall = 1'b1;
    conv(1'b1);
    conv(1'b0);
    conv(1'b1);
    drain();
    stall = 1'b0;
    cfg_delay_en = 1'b1;
    conv(1'b1);
    n = 0;
    // Look after the edge so the launched value is settled
    while (tx_valid !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("delay_span", 32'h1, 32'(n >= 2 * DELAY_UNIT_CYCLES && n < 2 * DELAY_UNIT_CYCLES + 20));
    drain();
    cfg_delay_en = 1'b0;
    while (conv_count < 2 * CAL_INTERVAL) begin
      conv(1'b1);
      drain();
    end
    check("cal_count", conv_count / CAL_INTERVAL, cal_count);
    stream_select_n = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    check("stream_active", 32'h0, stream_active);
    send_rx(2, 1'b1);
    repeat (4) @(posedge core_clk);
    tally_and_finish();
  end
endmodule
